//--- rtl/ptcmd_decoder.sv
// pass-through command block: registers, decode, descriptor send, status
// How it works
// RL1: code word must be the pass-through code, else error completion.
// RL2: option bit 0 gates the completion interrupt.
// RL3: gather bit swaps meaning of control, address, length, total fields.
// RL4: suppress bit on first command to a target stops sync until reset.
// RL5: option bit 8 sets direction: 0 writes VMEbus, 1 reads it.
// RL6: low vector byte for error completion, high byte for clean one.
// RL7: interrupt raised at level in low three bits; level 0 never fires.
// RL8: low byte of transfer control is the address modifier used.
// RL9: memory type 01 16-bit, 10 32-bit, 11 short I/O list, 00 refused.
// RL10: transfer kind 00 single, 01 block, 1x refused.
// RL11: host sets the chain flag only when chaining lists.
// RL12: transfer starts at the buffer pointer.
// RL13: no more bytes moved than the limit allows.
// RL14: under gather the total count word is the byte limit.
// RL15: target id from bits 0-2, lun from bits 3-5 of unit word.
// RL16: unit bit 6 picks primary or secondary port.
// RL17: descriptor bytes sent unchanged, count from group in byte 0.
// RL18: groups 6 and 7 take length from queue words minus 0x10.
// RL19: error code goes to the low byte of the result.
// RL20: target status byte goes unchanged to the high byte.
// RL21: host writes zero to all reserved bits.
// RL22: groups 0, 1, 5 give 6, 10, 12 descriptor bytes.
// RL23: vector chosen by error code; interrupt after result written.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module ptcmd_decoder
    import ptcmd_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    output logic BUSY,
    output target_s TARGET,
    output xfer_s XFER_CFG,
    output logic CDB_VALID,
    output logic [7:0] CDB_BYTE,
    output logic CDB_LAST,
    input wire logic CDB_READY,
    output logic XFER_ALLOW,
    input wire logic XFER_STB,
    input wire logic TARGET_DONE,
    input wire logic [7:0] TARGET_STATUS,
    input wire logic [7:0] TARGET_ERR,
    output logic IRQ_REQ,
    output logic [2:0] IRQ_LEVEL,
    output logic [7:0] IRQ_VECTOR,
    input wire logic IRQ_ACK
);
    // ========================================
    // state
    typedef struct packed {
        state_e state;
        logic [15:0] code;
        logic [15:0] opt;
        logic [15:0] vect;
        logic [15:0] level;
        logic [15:0] xctl;
        logic [31:0] buf_a;
        logic [31:0] len;
        logic [31:0] tot;
        logic [15:0] unit;
        logic [15:0] qlen;
        logic [5:0][15:0] cdb;
        logic [15:0] result;
        logic [7:0] err;
        logic [7:0] tstat;
        logic [7:0] cdb_len;
        logic [3:0] bidx;
        logic [7:0] cbyte;
        logic [31:0] moved;
        logic done;
        logic [7:0] irq_vec;
        logic [15:0] seen;
        logic [15:0] sync_off;
        logic [15:0] rdata;
    } st_s;

    st_s s;
    st_s next_s;
    logic [2:0] grp;
    logic [15:0] ud_words;
    logic [7:0] glen;
    logic [7:0] chk;
    logic [3:0] tix;
    logic [31:0] limit;
    logic [1:0] mt;
    logic [1:0] tt;
    logic last_byte;

    function automatic logic [7:0] cdb_pick(
        input logic [5:0][15:0] w,
        input logic [3:0] i
    );
        logic [15:0] word;
        word = w[i[3:1]];
        // byte 0 of a pair sits in the high half
        cdb_pick = i[0] ? word[7:0] : word[15:8];
    endfunction

    // ========================================
    // decode of the held command block
    assign grp = s.cdb[0][15:13];
    assign ud_words = s.qlen - CDB_OVERHEAD;
    assign mt = s.xctl[9:8];
    assign tt = s.xctl[11:10];
    assign tix = {s.unit[UNIT_BUS], s.unit[2:0]};
    // under gather the byte budget is the total of element counts
    assign limit = s.opt[OPT_SG] ? s.tot : s.len; // RL3 RL14
    assign last_byte = ({4'h0, s.bidx} == s.cdb_len - 8'h01);

    always_comb
    begin
        glen = 8'h00;
        unique case (grp)
            3'd0: glen = LEN_G0; // RL22
            3'd1: glen = LEN_G1; // RL22
            3'd5: glen = LEN_G5; // RL22
            3'd6, 3'd7:
            begin
                // only what fits the six held descriptor words
                if (s.qlen > CDB_OVERHEAD && ud_words <= CDB_WORDS)
                begin
                    glen = {ud_words[6:0], 1'b0}; // RL18
                end
            end
            default: glen = 8'h00;
        endcase
    end

    always_comb
    begin
        if (s.code != CMD_PASS)
        begin
            chk = ERR_CODE; // RL1
        end
        else if (glen == 8'h00)
        begin
            chk = ERR_GROUP; // RL17
        end
        else if (mt == MT_RSV || (mt == MT_SIO && !s.opt[OPT_SG]))
        begin
            chk = ERR_MT; // RL9
        end
        else if (tt[1])
        begin
            chk = ERR_TT; // RL10
        end
        else
        begin
            chk = ERR_NONE;
        end
    end

    // ========================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.rdata = 16'h0000;
        if (RD)
        begin
            unique case (ADDR)
                OFS_CODE: next_s.rdata = s.code;
                OFS_OPT: next_s.rdata = s.opt;
                OFS_RESULT: next_s.rdata = s.result;
                OFS_VECT: next_s.rdata = s.vect;
                OFS_LEVEL: next_s.rdata = s.level;
                OFS_XCTL: next_s.rdata = s.xctl;
                OFS_BUF_HI: next_s.rdata = s.buf_a[31:16];
                OFS_BUF_LO: next_s.rdata = s.buf_a[15:0];
                OFS_LEN_HI: next_s.rdata = s.len[31:16];
                OFS_LEN_LO: next_s.rdata = s.len[15:0];
                OFS_TOT_HI: next_s.rdata = s.tot[31:16];
                OFS_TOT_LO: next_s.rdata = s.tot[15:0];
                OFS_UNIT: next_s.rdata = s.unit;
                OFS_QLEN: next_s.rdata = s.qlen;
                OFS_STAT:
                begin
                    next_s.rdata = {13'h0000,
                        s.sync_off[tix], BUSY, s.done};
                end
                default:
                begin
                    if (ADDR >= OFS_CDB0 && ADDR <= OFS_CDB5)
                    begin
                        next_s.rdata = s.cdb[3'(ADDR - OFS_CDB0)];
                    end
                end
            endcase
        end
        // block contents are frozen while a command runs
        if (WR && s.state == ST_IDLE)
        begin
            unique case (ADDR)
                OFS_CODE: next_s.code = WDATA;
                OFS_OPT: next_s.opt = WDATA;
                OFS_VECT: next_s.vect = WDATA;
                OFS_LEVEL: next_s.level = WDATA;
                OFS_XCTL: next_s.xctl = WDATA;
                OFS_BUF_HI: next_s.buf_a[31:16] = WDATA;
                OFS_BUF_LO: next_s.buf_a[15:0] = WDATA;
                OFS_LEN_HI: next_s.len[31:16] = WDATA;
                OFS_LEN_LO: next_s.len[15:0] = WDATA;
                OFS_TOT_HI: next_s.tot[31:16] = WDATA;
                OFS_TOT_LO: next_s.tot[15:0] = WDATA;
                OFS_UNIT: next_s.unit = WDATA;
                OFS_QLEN: next_s.qlen = WDATA;
                OFS_CTRL:
                begin
                    if (WDATA[CTRL_CLR])
                    begin
                        next_s.done = 1'b0;
                    end
                    if (WDATA[CTRL_GO])
                    begin
                        next_s.state = ST_CHECK;
                        next_s.err = ERR_NONE;
                        next_s.tstat = 8'h00;
                    end
                end
                default:
                begin
                    if (ADDR >= OFS_CDB0 && ADDR <= OFS_CDB5)
                    begin
                        next_s.cdb[3'(ADDR - OFS_CDB0)] = WDATA;
                    end
                end
            endcase
        end
        unique case (s.state)
            ST_IDLE:
            begin
            end
            ST_CHECK:
            begin
                if (chk != ERR_NONE)
                begin
                    next_s.err = chk;
                    next_s.state = ST_FINISH;
                end
                else
                begin
                    next_s.cdb_len = glen; // RL17
                    next_s.bidx = 4'h0;
                    next_s.cbyte = cdb_pick(s.cdb, 4'h0);
                    next_s.moved = 32'h0;
                    if (!s.seen[tix])
                    begin
                        // only the first command to a target decides
                        next_s.seen[tix] = 1'b1;
                        next_s.sync_off[tix] = s.opt[OPT_SS]; // RL4
                    end
                    next_s.state = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (CDB_READY)
                begin
                    if (last_byte)
                    begin
                        next_s.state = ST_DATA;
                    end
                    else
                    begin
                        next_s.bidx = s.bidx + 4'h1;
                        next_s.cbyte = cdb_pick(s.cdb,
                            s.bidx + 4'h1); // RL17
                    end
                end
            end
            ST_DATA:
            begin
                if (XFER_STB && XFER_ALLOW)
                begin
                    next_s.moved = s.moved + 32'h1; // RL13
                end
                if (TARGET_DONE)
                begin
                    next_s.tstat = TARGET_STATUS;
                    next_s.err = TARGET_ERR;
                    next_s.state = ST_FINISH;
                end
            end
            ST_FINISH:
            begin
                next_s.result = {s.tstat, s.err}; // RL19 RL20
                next_s.done = 1'b1;
                next_s.irq_vec = (s.err != ERR_NONE) ?
                    s.vect[7:0] : s.vect[15:8]; // RL6 RL23
                // level 0 cannot signal, so it stays quiet
                if (s.opt[OPT_IE] && s.level[2:0] != 3'd0)
                begin
                    next_s.state = ST_IRQ; // RL2 RL7 RL23
                end
                else
                begin
                    next_s.state = ST_IDLE;
                end
            end
            ST_IRQ:
            begin
                if (IRQ_ACK)
                begin
                    next_s.state = ST_IDLE;
                end
            end
            default: next_s.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ========================================
    // outputs
    assign RDATA = s.rdata;
    assign BUSY = (s.state != ST_IDLE);
    assign TARGET.id = s.unit[2:0]; // RL15
    assign TARGET.lun = s.unit[5:3]; // RL15
    assign TARGET.port = s.unit[UNIT_BUS]; // RL16
    assign TARGET.sync_ok = !s.sync_off[tix]; // RL4
    assign XFER_CFG.am = s.xctl[7:0]; // RL8
    assign XFER_CFG.wide = (mt == MT_32); // RL9
    assign XFER_CFG.block = (tt == TT_BLOCK); // RL10
    assign XFER_CFG.rd = s.opt[OPT_DIR]; // RL5
    assign XFER_CFG.sg = s.opt[OPT_SG]; // RL3
    assign XFER_CFG.sg_sio = (mt == MT_SIO);
    assign XFER_CFG.addr = s.buf_a; // RL12
    assign XFER_CFG.limit = limit;
    assign CDB_VALID = (s.state == ST_SEND);
    assign CDB_BYTE = s.cbyte;
    assign CDB_LAST = CDB_VALID && last_byte;
    assign XFER_ALLOW = (s.state == ST_DATA) && (s.moved < limit); // RL13
    assign IRQ_REQ = (s.state == ST_IRQ);
    assign IRQ_LEVEL = s.level[2:0];
    assign IRQ_VECTOR = s.irq_vec;

    // ========================================
    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    bad_code_a: assert property ((s.state == ST_CHECK && // RL1
        s.code != CMD_PASS) |=> s.state == ST_FINISH && s.err == ERR_CODE)
        else $error("wrong code not refused");
    irq_gate_a: assert property (IRQ_REQ |-> s.opt[OPT_IE]) // RL2
        else $error("interrupt without enable");
    irq_level_a: assert property (IRQ_REQ |-> // RL7
        IRQ_LEVEL == s.level[2:0] && IRQ_LEVEL != 3'd0)
        else $error("interrupt level wrong");
    vector_pick_a: assert property ($rose(IRQ_REQ) |-> // RL6
        IRQ_VECTOR == (s.result[7:0] != 8'h00 ?
        s.vect[7:0] : s.vect[15:8]))
        else $error("vector choice wrong");
    irq_order_a: assert property ((s.state == ST_FINISH && // RL23
        s.opt[OPT_IE] && s.level[2:0] != 3'd0) |=> IRQ_REQ && s.done)
        else $error("interrupt not after result");
    status_copy_a: assert property ((s.state == ST_DATA && // RL20
        TARGET_DONE) |=> ##1 s.result == $past({TARGET_STATUS,
        TARGET_ERR}, 2))
        else $error("result not copied");
    byte_limit_a: assert property ((s.state == ST_DATA && // RL13
        XFER_STB && !XFER_ALLOW) |=> s.moved == $past(s.moved))
        else $error("limit overrun");
    dir_am_a: assert property ((s.state == ST_DATA && // RL5 RL8
        $past(s.state) == ST_DATA) |-> $stable(XFER_CFG))
        else $error("direction or modifier wrong");
    sync_hold_a: assert property (s.sync_off[tix] && // RL4
        s.state != ST_IDLE |=> s.sync_off == $past(s.sync_off))
        else $error("sync flag changed");
    cdb_count_a: assert property ((s.state == ST_CHECK && // RL22
        chk == ERR_NONE && grp == 3'd1) |=> s.cdb_len == LEN_G1)
        else $error("group 1 length wrong");

    clean_irq_c: cover property (IRQ_REQ && s.result == 16'h0000);
    error_done_c: cover property ($rose(s.done) && s.result[7:0] != 8'h0);
    user_group_c: cover property (CDB_LAST && grp == 3'd6);
endmodule

//--- rtl/ptcmd_pkg.sv
// package: register map, codes and carriers of the pass-through decoder
package ptcmd_pkg;
    // ========================================
    // register indices, one 16-bit word each
    localparam logic [5:0] OFS_CODE = 6'h00;
    localparam logic [5:0] OFS_OPT = 6'h01;
    localparam logic [5:0] OFS_RESULT = 6'h02;
    localparam logic [5:0] OFS_VECT = 6'h04;
    localparam logic [5:0] OFS_LEVEL = 6'h05;
    localparam logic [5:0] OFS_XCTL = 6'h07;
    localparam logic [5:0] OFS_BUF_HI = 6'h08;
    localparam logic [5:0] OFS_BUF_LO = 6'h09;
    localparam logic [5:0] OFS_LEN_HI = 6'h0a;
    localparam logic [5:0] OFS_LEN_LO = 6'h0b;
    localparam logic [5:0] OFS_TOT_HI = 6'h0c;
    localparam logic [5:0] OFS_TOT_LO = 6'h0d;
    localparam logic [5:0] OFS_UNIT = 6'h0f;
    localparam logic [5:0] OFS_CDB0 = 6'h10;
    localparam logic [5:0] OFS_CDB5 = 6'h15;
    localparam logic [5:0] OFS_QLEN = 6'h16;
    localparam logic [5:0] OFS_CTRL = 6'h17;
    localparam logic [5:0] OFS_STAT = 6'h18;
    // ========================================
    // field positions and codes
    localparam int OPT_IE = 0;
    localparam int OPT_SG = 1;
    localparam int OPT_SS = 2;
    localparam int OPT_DIR = 8;
    localparam int UNIT_BUS = 6;
    localparam int CTRL_GO = 0;
    localparam int CTRL_CLR = 1;
    localparam logic [15:0] CMD_PASS = 16'h0020;
    localparam logic [15:0] CDB_OVERHEAD = 16'h0010;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [1:0] MT_RSV = 2'b00;
    localparam logic [1:0] MT_32 = 2'b10;
    localparam logic [1:0] MT_SIO = 2'b11;
    localparam logic [1:0] TT_BLOCK = 2'b01;
    localparam logic [7:0] LEN_G0 = 8'h06;
    localparam logic [7:0] LEN_G1 = 8'h0a;
    localparam logic [7:0] LEN_G5 = 8'h0c;
    localparam logic [15:0] CDB_WORDS = 16'h0006;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_CODE = 8'h01;
    localparam logic [7:0] ERR_GROUP = 8'h02;
    localparam logic [7:0] ERR_MT = 8'h03;
    localparam logic [7:0] ERR_TT = 8'h04;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_SEND = 3'b010,
        ST_DATA = 3'b011,
        ST_FINISH = 3'b100,
        ST_IRQ = 3'b101
    } state_e;
    typedef struct packed {
        logic [2:0] id;
        logic [2:0] lun;
        logic port;
        logic sync_ok;
    } target_s;
    typedef struct packed {
        logic [7:0] am;
        logic wide;
        logic block;
        logic rd;
        logic sg;
        logic sg_sio;
        logic [31:0] addr;
        logic [31:0] limit;
    } xfer_s;
endpackage

//--- tb/ptcmd_target_model.sv
// far-side target model: takes descriptor bytes, moves data, reports
`timescale 1ns/1ns
module ptcmd_target_model(
    input wire logic clk,
    input wire logic cdb_valid,
    input wire logic [7:0] cdb_byte,
    input wire logic cdb_last,
    input wire logic xfer_allow,
    input wire logic slow,
    input wire logic [7:0] n_strobes,
    input wire logic [7:0] stat_in,
    input wire logic [7:0] err_in,
    output logic cdb_ready,
    output logic xfer_stb,
    output logic done,
    output logic [7:0] stat,
    output logic [7:0] err
);
    logic [7:0] got[$];
    int moved;
    // outside the done pulse the lines show no stale value
    assign stat = done ? stat_in : ~stat_in;
    assign err = done ? err_in : ~err_in;
    // ========================================
    // data phase: strobes beyond the allowance must not count
    task automatic move_data();
        repeat (2)
            @(posedge clk);
        repeat (n_strobes)
        begin
            xfer_stb <= 1'b1;
            @(posedge clk);
            if (xfer_allow === 1'b1)
                moved++;
            xfer_stb <= 1'b0;
            @(posedge clk);
        end
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
    endtask
    initial
    begin
        cdb_ready = 1'b0;
        xfer_stb = 1'b0;
        done = 1'b0;
        moved = 0;
        forever
        begin
            @(posedge clk);
            if (cdb_valid === 1'b1 && cdb_ready === 1'b1)
            begin
                got.push_back(cdb_byte);
                if (cdb_last === 1'b1)
                    move_data();
            end
            cdb_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
        end
    end
endmodule

//--- tb/ptcmd_decoder_test.sv
// self-checking bench for the pass-through command decoder
`timescale 1ns/1ns
module ptcmd_decoder_test;
    import ptcmd_pkg::*;
    logic REF_CLK, RST_B, WR, RD, BUSY, CDB_VALID, CDB_LAST, CDB_READY;
    logic XFER_ALLOW, XFER_STB, TARGET_DONE, IRQ_REQ, IRQ_ACK, slow;
    logic [5:0] ADDR;
    logic [15:0] WDATA, RDATA, rv, code, opt, vect, lvl, xctl, unit, qlen;
    logic [7:0] CDB_BYTE, TARGET_STATUS, TARGET_ERR, IRQ_VECTOR;
    logic [7:0] nstb, tstat, terr;
    logic [7:0] cdb[12];
    logic [2:0] IRQ_LEVEL;
    logic [31:0] bufa, len, tot;
    logic [5:0] ofs[13];
    logic [15:0] msk[13];
    target_s TARGET;
    xfer_s XFER_CFG;
    bit seen[16];
    bit off[16];
    int fail_count, samples_checked;
    ptcmd_decoder u_dut(.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BUSY(BUSY),
        .TARGET(TARGET), .XFER_CFG(XFER_CFG), .CDB_VALID(CDB_VALID),
        .CDB_BYTE(CDB_BYTE), .CDB_LAST(CDB_LAST), .CDB_READY(CDB_READY),
        .XFER_ALLOW(XFER_ALLOW), .XFER_STB(XFER_STB),
        .TARGET_DONE(TARGET_DONE), .TARGET_STATUS(TARGET_STATUS),
        .TARGET_ERR(TARGET_ERR), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
        .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACK(IRQ_ACK));
    ptcmd_target_model u_tgt(.clk(REF_CLK), .cdb_valid(CDB_VALID),
        .cdb_byte(CDB_BYTE), .cdb_last(CDB_LAST), .xfer_allow(XFER_ALLOW),
        .slow(slow), .n_strobes(nstb), .stat_in(tstat), .err_in(terr),
        .cdb_ready(CDB_READY), .xfer_stb(XFER_STB), .done(TARGET_DONE),
        .stat(TARGET_STATUS), .err(TARGET_ERR));
    // ========================================
    // bus tasks and reporting
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [79:0] seen_v, input logic [79:0] exp);
        samples_checked++;
        if (seen_v !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %h want %h", $time, seen_v, exp);
        end
    endtask
    task automatic timeout();
        fail_count++;
        $display("Error at %0t: no completion", $time);
        tally_and_finish();
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic do_reset();
        @(posedge REF_CLK);
        RST_B <= 1'b0;
        repeat (6)
            @(posedge REF_CLK);
        RST_B <= 1'b1;
        seen = '{default: 1'b0};
        off = '{default: 1'b0};
    endtask
    // ========================================
    // reference model of the command block
    function automatic int cdb_len();
        case (cdb[0][7:5])
            3'd0: return 6;
            3'd1: return 10;
            3'd5: return 12;
            3'd6, 3'd7: return (qlen > 16 && qlen < 23) ? 2 * (qlen - 16) : 0;
            default: return 0;
        endcase
    endfunction
    function automatic logic [7:0] exp_err();
        if (code !== CMD_PASS)
            return ERR_CODE;
        if (cdb_len() == 0)
            return ERR_GROUP;
        if (xctl[9:8] == MT_RSV || (xctl[9:8] == MT_SIO && !opt[OPT_SG]))
            return ERR_MT;
        if (xctl[11])
            return ERR_TT;
        return ERR_NONE;
    endfunction
    task automatic pick(input int g);
        code = CMD_PASS;
        opt = {7'h00, 1'($urandom), 7'h00, 1'b1};
        vect = 16'($urandom);
        lvl = 16'($urandom_range(7, 1));
        xctl = {4'h0, 2'($urandom_range(1)), 2'($urandom_range(2, 1)),
            8'($urandom)};
        bufa = $urandom;
        len = $urandom_range(9);
        tot = 0;
        unit = 16'($urandom_range(127));
        qlen = 16'h0000;
        foreach (cdb[i])
            cdb[i] = 8'($urandom);
        cdb[0][7:5] = 3'(g);
        nstb = 8'($urandom_range(8));
        tstat = 8'($urandom);
        terr = 8'h00;
        slow = 1'($urandom);
    endtask
    task automatic run(input string name);
        int n;
        logic [7:0] ee;
        logic [31:0] lim;
        logic [3:0] ix;
        logic [15:0] w[13];
        xfer_s xe;
        u_tgt.got.delete();
        u_tgt.moved = 0;
        w = '{code, opt, vect, lvl, xctl, bufa[31:16], bufa[15:0],
            len[31:16], len[15:0], tot[31:16], tot[15:0], unit, qlen};
        foreach (w[i])
            wr(ofs[i], w[i]);
        for (int i = 0; i < 6; i++)
            wr(OFS_CDB0 + 6'(i), {cdb[2 * i], cdb[2 * i + 1]});
        wr(OFS_CTRL, 16'h0001);
        // a write while busy must be dropped
        wr(OFS_OPT, ~opt);
        rv = 16'h0000;
        n = 0;
        while (rv[0] !== 1'b1)
        begin
            rd(OFS_STAT, rv);
            n++;
            if (n > 300)
                timeout();
        end
        ee = exp_err();
        ix = {unit[6], unit[2:0]};
        if (ee == ERR_NONE && !seen[ix])
        begin
            seen[ix] = 1'b1;
            off[ix] = opt[OPT_SS];
        end
        chk(rv[2], off[ix]);
        lim = opt[OPT_SG] ? tot : len;
        xe = {xctl[7:0], xctl[9:8] == MT_32, xctl[11:10] == TT_BLOCK,
            opt[OPT_DIR], opt[OPT_SG], xctl[9:8] == MT_SIO, bufa, lim};
        chk(XFER_CFG, xe);
        chk(TARGET, {unit[2:0], unit[5:3], unit[6], !off[ix]});
        n = ee == ERR_NONE ? cdb_len() : 0;
        chk(u_tgt.got.size(), n);
        foreach (u_tgt.got[i])
            chk(u_tgt.got[i], cdb[i]);
        rd(OFS_RESULT, rv);
        if (ee == ERR_NONE)
        begin
            chk(rv[15:8], tstat);
            chk(u_tgt.moved, nstb < lim ? nstb : lim);
            ee = terr;
        end
        chk(rv[7:0], ee);
        n = opt[OPT_IE] && lvl[2:0] != 3'h0;
        chk(IRQ_REQ, n);
        if (n)
        begin
            chk(IRQ_LEVEL, lvl[2:0]);
            chk(IRQ_VECTOR, ee != 0 ? vect[7:0] : vect[15:8]);
            @(posedge REF_CLK);
            IRQ_ACK <= 1'b1;
            @(posedge REF_CLK);
            IRQ_ACK <= 1'b0;
        end
        n = 0;
        while (BUSY !== 1'b0)
        begin
            @(posedge REF_CLK);
            n++;
            if (n > 20)
                timeout();
        end
        wr(OFS_CTRL, 16'h0002);
        $display("test %s done", name);
    endtask
    // ========================================
    // main sequence
    initial
    begin
        REF_CLK = 1'b0;
        forever
            #25 REF_CLK = ~REF_CLK;
    end
    initial
    begin
        logic [15:0] v[13];
        {RST_B, WR, RD, IRQ_ACK, slow} = 5'h00;
        {ADDR, WDATA, nstb, tstat, terr} = '0;
        ofs = '{OFS_CODE, OFS_OPT, OFS_VECT, OFS_LEVEL, OFS_XCTL, OFS_BUF_HI,
            OFS_BUF_LO, OFS_LEN_HI, OFS_LEN_LO, OFS_TOT_HI, OFS_TOT_LO,
            OFS_UNIT, OFS_QLEN};
        msk = '{16'hffff, 16'h0107, 16'hffff, 16'h0007, 16'h8fff, 16'hffff,
            16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h007f,
            16'hffff};
        void'($urandom(36039));
        do_reset();
        foreach (ofs[i])
        begin
            rd(ofs[i], rv);
            chk(rv, RESET_WORD);
            v[i] = 16'($urandom) & msk[i];
            wr(ofs[i], v[i]);
        end
        foreach (ofs[i])
        begin
            rd(ofs[i], rv);
            chk(rv, v[i]);
        end
        wr(OFS_RESULT, 16'hffff);
        rd(OFS_RESULT, rv);
        chk(rv, RESET_WORD);
        rd(6'h3f, rv);
        chk(rv, 16'h0000);
        $display("test registers done");
        for (int g = 0; g < 8; g++)
        begin
            pick(g);
            run("group code");
        end
        for (int q = 16; q < 24; q++)
        begin
            pick(6 + q % 2);
            qlen = 16'(q);
            terr = 8'(q % 3);
            run("user group length");
        end
        for (int k = 0; k < 5; k++)
        begin
            pick(0);
            case (k)
                0: code = 16'h0022;
                1: xctl[9:8] = MT_RSV;
                2: xctl[9:8] = MT_SIO;
                default: xctl[11:10] = 2'(k - 1);
            endcase
            run("refused field");
        end
        pick(1);
        len = 0;
        nstb = 8;
        run("zero length");
        pick(5);
        opt[OPT_SG] = 1'b1;
        xctl[9:8] = MT_SIO;
        tot = 2;
        len = 9;
        nstb = 7;
        run("gather");
        pick(0);
        opt[OPT_IE] = 1'b0;
        run("no interrupt");
        pick(0);
        lvl = 16'h0000;
        run("level zero");
        do_reset();
        for (int k = 0; k < 4; k++)
        begin
            pick(0);
            unit = k == 2 ? 16'h0043 : 16'h0003;
            opt[OPT_SS] = k == 0;
            run("sync suppress");
        end
        do_reset();
        pick(0);
        unit = 16'h0003;
        run("sync after reset");
        tally_and_finish();
    end
endmodule
